// [shared/ddp_defs.svh]
// Constants for the data memory decoder and dual pointer bank
`ifndef DDP_DEFS_SVH
`define DDP_DEFS_SVH

// ********************************************
// Special register addresses
// ********************************************
`define DDP_SFR_PTR_LO   8'h82
`define DDP_SFR_PTR_HI   8'h83
`define DDP_SFR_AUX      8'ha2

// ********************************************
// Field positions and reset values
// ********************************************
`define DDP_SEL_BIT      0
`define DDP_PTR_RST      16'h0000
`define DDP_AUX_RST      1'b0

// ********************************************
// Address boundaries
// ********************************************
`define DDP_ESFR_BASE    8'h30
`define DDP_EXTRA_BASE   8'hc0
`define DDP_XRAM_TOP     16'h1fff

`endif

// [shared/ddp_pkg.sv]
// Types shared by the data memory decoder, the CPU model and the testbench
package ddp_pkg;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_XMOVE,
    MODE_FETCH
  } ddp_mode_t;

  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_LOW_RAM,
    TGT_ESFR,
    TGT_SFR,
    TGT_UPPER_RAM,
    TGT_EXTRA_RAM,
    TGT_XRAM,
    TGT_XEXT,
    TGT_FLASH
  } ddp_target_t;

  typedef struct packed {
    logic      valid;
    logic      we;
    ddp_mode_t mode;
    logic      use_ptr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ddp_req_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    ddp_target_t target;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ddp_route_t;

endpackage : ddp_pkg

// [src/ddp_pointer_bank.sv]
// Two 16-bit data pointers behind one register pair, plus the select register
`timescale 1ns/100ps
`include "ddp_defs.svh"

module ddp_pointer_bank (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_inc,
  output logic      [15:0] o_ptr,
  output logic             o_sel,
  output logic      [7:0]  o_rdata
);

  logic [15:0] ptr_q [2];
  logic        sel_q;

  // ********************************************
  // Pointer select
  // ********************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= `DDP_AUX_RST;
    end else if (i_ce && i_wr && i_addr == `DDP_SFR_AUX) begin
      sel_q <= i_wdata[`DDP_SEL_BIT];
    end
  end

  // ********************************************
  // Pointers
  // ********************************************
  // Only the selected pointer moves; the other keeps its value untouched
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_q[0] <= `DDP_PTR_RST;
      ptr_q[1] <= `DDP_PTR_RST;
    end else if (i_ce) begin
      if (i_wr && i_addr == `DDP_SFR_PTR_LO) begin
        ptr_q[sel_q][7:0] <= i_wdata;
      end else if (i_wr && i_addr == `DDP_SFR_PTR_HI) begin
        ptr_q[sel_q][15:8] <= i_wdata;
      end else if (i_inc) begin
        ptr_q[sel_q] <= ptr_q[sel_q] + 16'h0001;
      end
    end
  end

  assign o_ptr = ptr_q[sel_q];
  assign o_sel = sel_q;

  // Reserved select bits read as zero
  always_comb begin
    unique case (i_addr)
      `DDP_SFR_PTR_LO: o_rdata = ptr_q[sel_q][7:0];
      `DDP_SFR_PTR_HI: o_rdata = ptr_q[sel_q][15:8];
      `DDP_SFR_AUX:    o_rdata = {7'h00, sel_q};
      default:         o_rdata = 8'h00;
    endcase
  end

  // ********************************************
  // Checks
  // ********************************************
  a_other_ptr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(i_ce && i_wr && i_addr == `DDP_SFR_AUX) |=> $stable(ptr_q[!sel_q]))
    else $error("Unselected pointer changed");

  a_sel_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_wr && i_addr == `DDP_SFR_AUX |=> sel_q == $past(i_wdata[`DDP_SEL_BIT]))
    else $error("Pointer select not written");

endmodule : ddp_pointer_bank

// [src/ddp_decode.sv]
// Data memory address decoder with dual data pointer
`timescale 1ns/100ps
`include "ddp_defs.svh"

// Notes on behaviour
// - Low 128 internal bytes are RAM, both modes
// - 30H-7FH may map as extended special registers
// - Upper half: direct to SFR, indirect to RAM
// - Top 64 bytes: extra RAM, indirect only
// - External space 64K, external move only
// - External move up to 1FFFH hits on-chip RAM
// - Above 1FFFH no expansion target exists
// - Instruction space separate, 64K, all flash
// - Each pointer 16 bits, addresses external space
// - Two pointers share 83H high, 82H low
// - Select bit picks the active pointer
// - Select bit lives in register A2H

module ddp_decode (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_ce,
  input  wire logic                i_esfr_map,
  input  wire logic                i_extra_ram_en,
  input  wire logic                i_ptr_inc,
  input  wire ddp_pkg::ddp_req_t   i_req,
  output ddp_pkg::ddp_route_t      o_route,
  output logic               [7:0] o_sfr_rdata,
  output logic                     o_sfr_ack,
  output logic                     o_ext_miss,
  output logic                     o_ptr_sel,
  output logic              [15:0] o_data_pointer
);

  // ********************************************
  // Reset release
  // ********************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ********************************************
  // Decode functions
  // ********************************************
  function automatic logic ptr_sfr_hit(input ddp_pkg::ddp_req_t r);
    logic a;
    a = r.valid && r.mode == ddp_pkg::MODE_DIRECT && r.addr[15:8] == 8'h00;
    return a && (r.addr[7:0] == `DDP_SFR_PTR_LO || r.addr[7:0] == `DDP_SFR_PTR_HI
                 || r.addr[7:0] == `DDP_SFR_AUX);
  endfunction : ptr_sfr_hit

  function automatic ddp_pkg::ddp_route_t route_of(
    input ddp_pkg::ddp_req_t r,
    input logic [15:0]       ptr,
    input logic              esfr,
    input logic              xtra
  );
    ddp_pkg::ddp_route_t o;
    logic [7:0]          ia;
    logic [15:0]         xa;
    ia       = r.addr[7:0];
    xa       = r.use_ptr ? ptr : r.addr;
    o.valid  = r.valid;
    o.we     = r.we;
    o.wdata  = r.wdata;
    o.addr   = {8'h00, ia};
    o.target = ddp_pkg::TGT_NONE;
    unique case (r.mode)
      ddp_pkg::MODE_DIRECT: begin
        if (ia[7]) begin
          o.target = ddp_pkg::TGT_SFR;
        end else if (esfr && ia >= `DDP_ESFR_BASE) begin
          o.target = ddp_pkg::TGT_ESFR;
        end else begin
          o.target = ddp_pkg::TGT_LOW_RAM;
        end
      end
      ddp_pkg::MODE_INDIRECT: begin
        if (!ia[7]) begin
          o.target = (esfr && ia >= `DDP_ESFR_BASE) ? ddp_pkg::TGT_ESFR
                                                      : ddp_pkg::TGT_LOW_RAM;
        end else if (xtra && ia >= `DDP_EXTRA_BASE) begin
          o.target = ddp_pkg::TGT_EXTRA_RAM;
        end else begin
          o.target = ddp_pkg::TGT_UPPER_RAM;
        end
      end
      ddp_pkg::MODE_XMOVE: begin
        o.addr   = xa;
        o.target = (xa <= `DDP_XRAM_TOP) ? ddp_pkg::TGT_XRAM
                                           : ddp_pkg::TGT_XEXT;
        // No device behind the upper range, so a write there is dropped
        o.we     = r.we && xa <= `DDP_XRAM_TOP;
      end
      ddp_pkg::MODE_FETCH: begin
        o.addr   = r.addr;
        o.target = ddp_pkg::TGT_FLASH;
        o.we     = 1'b0;
      end
    endcase
    if (!r.valid) begin
      o.target = ddp_pkg::TGT_NONE;
      o.we     = 1'b0;
    end
    return o;
  endfunction : route_of

  // ********************************************
  // Pointer bank
  // ********************************************
  logic [15:0] cur_ptr;
  logic        cur_sel;
  logic [7:0]  bank_rdata;
  logic        ptr_wr;

  assign ptr_wr = ptr_sfr_hit(i_req) && i_req.we;

  ddp_pointer_bank u_bank (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_q),
    .i_ce    (i_ce),
    .i_wr    (ptr_wr),
    .i_addr  (i_req.addr[7:0]),
    .i_wdata (i_req.wdata),
    .i_inc   (i_ptr_inc),
    .o_ptr   (cur_ptr),
    .o_sel   (cur_sel),
    .o_rdata (bank_rdata)
  );

  // ********************************************
  // Routed access
  // ********************************************
  ddp_pkg::ddp_route_t route_d;

  assign route_d = route_of(i_req, cur_ptr, i_esfr_map, i_extra_ram_en);

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_route <= '0;
    end else if (i_ce) begin
      o_route <= route_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_ext_miss <= 1'b0;
    end else if (i_ce) begin
      o_ext_miss <= route_d.target == ddp_pkg::TGT_XEXT;
    end
  end

  // ********************************************
  // Pointer register reads
  // ********************************************
  // Read data is the value before any write in the same cycle
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_sfr_ack   <= 1'b0;
      o_sfr_rdata <= 8'h00;
    end else if (i_ce) begin
      o_sfr_ack   <= ptr_sfr_hit(i_req);
      o_sfr_rdata <= ptr_sfr_hit(i_req) && !i_req.we ? bank_rdata : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_ptr_sel      <= 1'b0;
      o_data_pointer <= `DDP_PTR_RST;
    end else if (i_ce) begin
      o_ptr_sel      <= cur_sel;
      o_data_pointer <= cur_ptr;
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  logic req_go;
  assign req_go = i_ce && i_req.valid;

  a_low_ram_route: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode != ddp_pkg::MODE_XMOVE && i_req.mode != ddp_pkg::MODE_FETCH
      && !i_req.addr[7] && !i_esfr_map
    |=> o_route.target == ddp_pkg::TGT_LOW_RAM)
    else $error("Low internal access not routed to RAM");

  a_esfr_route: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_DIRECT && i_esfr_map && !i_req.addr[7]
      && i_req.addr[7:0] >= `DDP_ESFR_BASE
    |=> o_route.target == ddp_pkg::TGT_ESFR)
    else $error("Mapped 30H-7FH not routed to extended registers");

  a_upper_split: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.addr[7] && i_req.mode == ddp_pkg::MODE_DIRECT
    |=> o_route.target == ddp_pkg::TGT_SFR && o_route.addr[15:8] == 8'h00)
    else $error("Direct upper access not routed to SFR");

  a_extra_ram: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_INDIRECT && i_extra_ram_en
      && i_req.addr[7:0] >= `DDP_EXTRA_BASE
    |=> o_route.target == ddp_pkg::TGT_EXTRA_RAM)
    else $error("Indirect top access not routed to extra RAM");

  a_xram_bound: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_XMOVE && !i_req.use_ptr
    |=> (o_route.target == ddp_pkg::TGT_XRAM) == (o_route.addr <= `DDP_XRAM_TOP))
    else $error("External move boundary wrong");

  a_no_expansion: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    o_route.target == ddp_pkg::TGT_XEXT |-> !o_route.we && o_ext_miss)
    else $error("Write reached missing external memory");

  a_fetch_flash: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_FETCH
    |=> o_route.target == ddp_pkg::TGT_FLASH && o_route.addr == $past(i_req.addr))
    else $error("Fetch not sent to flash");

  a_ptr_addr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_XMOVE && i_req.use_ptr
    |=> o_route.addr == o_data_pointer)
    else $error("External move did not use the active pointer");

  a_ptr_readback: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_ce && ptr_wr && i_req.addr[7:0] == `DDP_SFR_PTR_HI && !i_ptr_inc
      ##1 i_ce && i_req.valid && !i_req.we && i_req.mode == ddp_pkg::MODE_DIRECT
      && i_req.addr == 16'h0083
    |=> o_sfr_ack && o_sfr_rdata == $past(i_req.wdata, 2))
    else $error("High pointer byte readback wrong");

  a_reset_state: assert property (@(posedge i_clk)
    $rose(rst_n_q) |-> !o_ptr_sel && o_data_pointer == 16'h0000)
    else $error("Pointer state not cleared by reset");

  a_upper_ram: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_INDIRECT && i_req.addr[7] && !i_extra_ram_en
    |=> o_route.target == ddp_pkg::TGT_UPPER_RAM)
    else $error("Indirect upper access not routed to RAM");

  a_esfr_indirect: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_INDIRECT && i_esfr_map && !i_req.addr[7]
      && i_req.addr[7:0] >= `DDP_ESFR_BASE
    |=> o_route.target == ddp_pkg::TGT_ESFR)
    else $error("Indirect mapped access not routed to extended registers");

  a_internal_addr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && (i_req.mode == ddp_pkg::MODE_DIRECT || i_req.mode == ddp_pkg::MODE_INDIRECT)
    |=> o_route.addr[15:8] == 8'h00)
    else $error("Internal access left the internal space");

  a_xmove_addr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_XMOVE && !i_req.use_ptr
    |=> o_route.addr == $past(i_req.addr))
    else $error("External move address not passed whole");

  a_fetch_read_only: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_FETCH |=> !o_route.we)
    else $error("Fetch carried a write");

  a_miss_only_xmove: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_ce && !(i_req.valid && i_req.mode == ddp_pkg::MODE_XMOVE) |=> !o_ext_miss)
    else $error("Miss flagged without an external move");

  a_aux_ack: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    req_go && i_req.mode == ddp_pkg::MODE_DIRECT && i_req.addr == {8'h00, `DDP_SFR_AUX}
    |=> o_sfr_ack)
    else $error("Select register access not acknowledged");

  a_sel_copy: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_ce && ptr_wr && i_req.addr[7:0] == `DDP_SFR_AUX ##1 i_ce
    |=> o_ptr_sel == $past(i_req.wdata[`DDP_SEL_BIT], 2))
    else $error("Written select bit not shown on output");

  a_write_no_data: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_ce && ptr_wr |=> o_sfr_ack && o_sfr_rdata == 8'h00)
    else $error("Register write returned read data");

  a_frozen_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !i_ce |=> $stable(o_route) && $stable(o_sfr_ack) && $stable(o_data_pointer))
    else $error("Outputs moved while clock enable was low");

  // ********************************************
  // Cover points
  // ********************************************
  c_ptr_switch: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    $rose(o_ptr_sel));
  c_xram_hit: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    o_route.valid && o_route.target == ddp_pkg::TGT_XRAM);
  c_ext_miss: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    o_ext_miss);
  c_extra_ram: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    o_route.target == ddp_pkg::TGT_EXTRA_RAM);
  c_raw_readback: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    i_ce && ptr_wr ##1 i_ce && i_req.valid && !i_req.we && i_req.mode == ddp_pkg::MODE_DIRECT);

endmodule : ddp_decode

// [verification/ddp_cpu_model.sv]
// CPU core model issuing data and fetch requests to the decoder
`timescale 1ns/100ps

module ddp_cpu_model (
  input  wire logic         i_clk,
  output ddp_pkg::ddp_req_t o_req
);
  // ********************************************
  // Request issue
  // ********************************************
  initial begin
    o_req = '0;
  end

  // One request per call, launched just after an edge and taken at the next
  task automatic access(input logic we, input ddp_pkg::ddp_mode_t mode, input logic use_ptr,
                        input logic [15:0] addr, input logic [7:0] wdata);
    @(posedge i_clk);
    #1;
    o_req = '{1'b1, we, mode, use_ptr, addr, wdata};
    @(posedge i_clk);
    #1;
    // Released lines other than mode show the inverse, so a stale value never passes for a live one
    o_req = '{1'b0, ~we, mode, ~use_ptr, ~addr, ~wdata};
  endtask : access

  // Direct write then direct read of the same address on consecutive edges
  task automatic pair(input logic [15:0] addr, input logic [7:0] wdata);
    @(posedge i_clk);
    #1;
    o_req = '{1'b1, 1'b1, ddp_pkg::MODE_DIRECT, 1'b0, addr, wdata};
    @(posedge i_clk);
    #1;
    o_req = '{1'b1, 1'b0, ddp_pkg::MODE_DIRECT, 1'b0, addr, ~wdata};
    @(posedge i_clk);
    #1;
    o_req = '{1'b0, 1'b1, ddp_pkg::MODE_DIRECT, 1'b1, ~addr, wdata};
  endtask : pair
endmodule : ddp_cpu_model

// [verification/testbench.sv]
// Self-checking bench for the data memory decoder and pointer bank
`timescale 1ns/100ps

module testbench;
  logic                clk;
  logic                rst_n;
  logic                ce;
  logic                esfr;
  logic                xtra;
  logic                inc;
  ddp_pkg::ddp_req_t   req;
  ddp_pkg::ddp_route_t route;
  logic [7:0]          rdata;
  logic                ack;
  logic                miss;
  logic                sel;
  logic [15:0]         ptr;
  logic [15:0]         tbl [11];
  ddp_pkg::ddp_target_t et;
  int                  n_mismatch = 0;
  int                  checked = 0;

  ddp_cpu_model u_cpu (.i_clk(clk), .o_req(req));
  ddp_decode u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_esfr_map(esfr), .i_extra_ram_en(xtra),
                    .i_ptr_inc(inc), .i_req(req), .o_route(route), .o_sfr_rdata(rdata), .o_sfr_ack(ack),
                    .o_ext_miss(miss), .o_ptr_sel(sel), .o_data_pointer(ptr));

  // ********************************************
  // Helpers
  // ********************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_cpu.access(1'b0, ddp_pkg::MODE_DIRECT, 1'b0, {8'h00, a}, 8'h00);
    chk("sfr ack", 16'h0001, {15'h0000, ack});
    chk("sfr read", {8'h00, e}, {8'h00, rdata});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cpu.access(1'b1, ddp_pkg::MODE_DIRECT, 1'b0, {8'h00, a}, d);
    chk("sfr ack", 16'h0001, {15'h0000, ack});
  endtask : wr

  // Pointer-based external move; checks the address and where it lands
  task automatic xptr(input logic [15:0] e);
    u_cpu.access(1'b0, ddp_pkg::MODE_XMOVE, 1'b1, 16'hffff, 8'h00);
    chk("xmove addr", e, route.addr);
    chk("xmove miss", {15'h0000, e > 16'h1fff}, {15'h0000, miss});
  endtask : xptr

  function automatic ddp_pkg::ddp_target_t tgt(input ddp_pkg::ddp_mode_t m, input logic [15:0] a);
    tgt = ddp_pkg::TGT_FLASH;
    if (m == ddp_pkg::MODE_XMOVE) begin
      tgt = (a <= 16'h1fff) ? ddp_pkg::TGT_XRAM : ddp_pkg::TGT_XEXT;
    end else if (m != ddp_pkg::MODE_FETCH) begin
      if (a[7:0] < 8'h80) begin
        tgt = (esfr && a[7:0] >= 8'h30) ? ddp_pkg::TGT_ESFR : ddp_pkg::TGT_LOW_RAM;
      end else if (m == ddp_pkg::MODE_DIRECT) begin
        tgt = ddp_pkg::TGT_SFR;
      end else begin
        tgt = (xtra && a[7:0] >= 8'hc0) ? ddp_pkg::TGT_EXTRA_RAM : ddp_pkg::TGT_UPPER_RAM;
      end
    end
  endfunction : tgt

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ********************************************
  // Clock, watchdog and sequence
  // ********************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    tbl = '{16'h0000, 16'h002f, 16'h0030, 16'h007f, 16'h0080, 16'h00bf, 16'h00c0, 16'h00ff,
            16'h1fff, 16'h2000, 16'hffff};
    rst_n = 1'b0;
    ce = 1'b1;
    esfr = 1'b0;
    xtra = 1'b0;
    inc = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'ha2, 8'h00);
    chk("pointer", 16'h0000, ptr);
    chk("select", 16'h0000, {15'h0000, sel});
    // Every mode across every boundary, under all four mapping choices
    for (int k = 0; k < 4; k++) begin
      {esfr, xtra} = k[1:0];
      for (int m = 0; m < 4; m++) begin
        for (int i = 0; i < 11; i++) begin
          u_cpu.access(1'b1, ddp_pkg::ddp_mode_t'(m), 1'b0, tbl[i], 8'h5a);
          et = tgt(ddp_pkg::ddp_mode_t'(m), tbl[i]);
          chk("target", {12'h000, et}, {12'h000, route.target});
          chk("route addr", (m < 2) ? {8'h00, tbl[i][7:0]} : tbl[i], route.addr);
          chk("route we", {15'h0000, m < 3 && et != ddp_pkg::TGT_XEXT}, {15'h0000, route.we});
          chk("miss", {15'h0000, et == ddp_pkg::TGT_XEXT}, {15'h0000, miss});
          chk("route data", {7'h00, 1'b1, 8'h5a}, {7'h00, route.valid, route.wdata});
        end
      end
    end
    wr(8'h83, 8'h12);
    wr(8'h82, 8'h34);
    rd(8'h83, 8'h12);
    rd(8'h82, 8'h34);
    chk("pointer", 16'h1234, ptr);
    xptr(16'h1234);
    wr(8'h83, 8'hab);
    xptr(16'hab34);
    wr(8'ha2, 8'hff);
    rd(8'ha2, 8'h01);
    chk("select", 16'h0001, {15'h0000, sel});
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    u_cpu.pair(16'h0083, 8'h20);
    chk("raw ack", 16'h0001, {15'h0000, ack});
    chk("raw read", 16'h0020, {8'h00, rdata});
    wr(8'h83, 8'h20);
    wr(8'h82, 8'h01);
    xptr(16'h2001);
    @(posedge clk);
    #1;
    inc = 1'b1;
    @(posedge clk);
    #1;
    inc = 1'b0;
    rd(8'h82, 8'h02);
    wr(8'ha2, 8'h00);
    rd(8'ha2, 8'h00);
    xptr(16'hab34);
    chk("pointer", 16'hab34, ptr);
    // A frozen clock enable must not take the request
    ce = 1'b0;
    u_cpu.access(1'b0, ddp_pkg::MODE_DIRECT, 1'b0, 16'h0083, 8'h00);
    chk("frozen ack", 16'h0000, {15'h0000, ack});
    ce = 1'b1;
    rd(8'h83, 8'hab);
    end_of_test();
  end
endmodule : testbench
